// file: logic/mcr_pkg.sv
// package: register map, fields and reset values of the misc config bank
`default_nettype none
package mcr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SEG_COUNT = 42;
  localparam int SEG_W = 4;
  localparam int DIV_W = 3;
  localparam int DIV_STEPS = 128;
  localparam int CNT_W = 7;
  // byte offsets
  localparam logic [15:0] MUX_CTL_ADDR = 16'h2002;
  localparam logic [15:0] CPU_DIV_ADDR = 16'h2004;
  localparam logic [15:0] MUX_SEL_ADDR = 16'h2005;
  localparam logic [15:0] OPT_CTL_ADDR = 16'h2008;
  localparam logic [15:0] SEG_FIRST_ADDR = 16'h2030;
  localparam logic [15:0] SEG_LAST_ADDR = 16'h2059;
  // field positions
  localparam int STATE_CNT_LSB = 6;
  localparam int DIV_LSB = 0;
  localparam int SYNC_EN_BIT = 0;
  localparam int ALT_SEL_BIT = 2;
  localparam int OPT_DIS_BIT = 5;
  localparam int SEG_PIN_SYNC = 7;
  // reset values
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [1:0] STATE_CNT_RESET = 2'h0;
  localparam logic SYNC_EN_RESET = 1'b0;
  localparam logic ALT_SEL_RESET = 1'b0;
  localparam logic OPT_DIS_RESET = 1'b0;
  localparam logic [3:0] SEG_RESET = 4'h0;
  // state counts per encoding
  localparam logic [2:0] STATES_00 = 3'h6;
  localparam logic [2:0] STATES_01 = 3'h4;
  localparam logic [2:0] STATES_10 = 3'h3;
  localparam logic [2:0] STATES_11 = 3'h2;
endpackage : mcr_pkg
`default_nettype wire

// file: logic/mcr_clk_div.sv
// glitch-free cpu clock enable divider
`default_nettype none
module mcr_clk_div
  import mcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [mcr_pkg::DIV_W-1:0] div_sel,
  output logic cpu_clk_en,
  output logic [mcr_pkg::DIV_W-1:0] div_active
);
  logic [CNT_W-1:0] cnt_r;
  logic [DIV_W-1:0] act_r;
  logic [CNT_W-1:0] last;
  assign last = CNT_W'((DIV_STEPS'(1) << act_r) - 1);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (cnt_r >= last) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end
  // switch only at period end, so no runt pulse or stall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= DIV_RESET;
    end else if (cnt_r >= last) begin
      act_r <= div_sel;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= (cnt_r >= last);
    end
  end
  assign div_active = act_r;
endmodule : mcr_clk_div
`default_nettype wire

// file: logic/mcr_seg_word.sv
// one 4-bit lcd segment data word
`default_nettype none
module mcr_seg_word
  import mcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [mcr_pkg::SEG_W-1:0] wr_data,
  output logic [mcr_pkg::SEG_W-1:0] seg_word
);
  // bit n drives common phase n
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seg_word <= SEG_RESET;
    end else if (wr_en) begin
      seg_word <= wr_data;
    end
  end
endmodule : mcr_seg_word
`default_nettype wire

// file: logic/mcr_bank.sv
// misc configuration register bank: mux, cpu clock, optical and lcd words
// Overview of operation
// - segment word bit n is common phase n
// - cpu clock divided by two to field
// - divider changes without glitch or lockup
// - divider field clears to zero at reset
// - alternate bit routes conversions to alternate inputs
// - state count field selects 6,4,3,2 states
// - sync enable turns segment seven into sync
// - disable bit tristates optical transmit output
`default_nettype none
module mcr_bank
  import mcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [mcr_pkg::ADDR_W-1:0] addr,
  input wire logic [mcr_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [mcr_pkg::DATA_W-1:0] rdata,
  input wire logic input_output_a,
  input wire logic optical_tx_data,
  output logic cpu_clk_en,
  output logic input_mux_alternate_select,
  output logic [2:0] input_mux_states,
  output logic [mcr_pkg::SEG_W-1:0] lcd_segment_pin_seven,
  output logic input_input_output_a_enable,
  output logic optical_transmit_output,
  output logic optical_transmit_output_oe_n,
  output logic [mcr_pkg::SEG_COUNT*mcr_pkg::SEG_W-1:0] lcd_segment_words
);
  import mcr_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] base);
    hit = (a == base);
  endfunction : hit

  function automatic logic seg_hit(input logic [ADDR_W-1:0] a);
    seg_hit = (a >= SEG_FIRST_ADDR) && (a <= SEG_LAST_ADDR);
  endfunction : seg_hit

  logic [1:0] state_cnt_r;
  logic [DIV_W-1:0] cpu_div_r;
  logic sync_en_r;
  logic alt_sel_r;
  logic opt_dis_r;
  logic sync_m_r;
  logic sync_s_r;
  logic opt_m_r;
  logic opt_s_r;
  logic [SEG_W-1:0] seg_words [SEG_COUNT];
  logic [5:0] seg_idx;
  logic cpu_en_int;
  logic [2:0] states_nxt;
  logic [DATA_W-1:0] rdata_nxt;

  assign seg_idx = 6'(addr - SEG_FIRST_ADDR);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_cnt_r <= STATE_CNT_RESET;
    end else if (wr_stb && hit(addr, MUX_CTL_ADDR)) begin
      state_cnt_r <= wdata[STATE_CNT_LSB +: 2];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_div_r <= DIV_RESET;
    end else if (wr_stb && hit(addr, CPU_DIV_ADDR)) begin
      cpu_div_r <= wdata[DIV_LSB +: DIV_W];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_en_r <= SYNC_EN_RESET;
      alt_sel_r <= ALT_SEL_RESET;
    end else if (wr_stb && hit(addr, MUX_SEL_ADDR)) begin
      sync_en_r <= wdata[SYNC_EN_BIT];
      alt_sel_r <= wdata[ALT_SEL_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      opt_dis_r <= OPT_DIS_RESET;
    end else if (wr_stb && hit(addr, OPT_CTL_ADDR)) begin
      opt_dis_r <= wdata[OPT_DIS_BIT];
    end
  end

  mcr_clk_div u_div (
    .clock(clock),
    .rst_n(rst_n),
    .div_sel(cpu_div_r),
    .cpu_clk_en(cpu_en_int),
    .div_active()
  );

  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++) begin : g_seg
      mcr_seg_word u_word (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(wr_stb && seg_hit(addr) && (seg_idx == 6'(g))),
        .wr_data(wdata[SEG_W-1:0]),
        .seg_word(seg_words[g])
      );
      // words packed, bit n is phase n
      assign lcd_segment_words[g*SEG_W +: SEG_W] = seg_words[g];
    end
  endgenerate

  // pin inputs cross in through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      opt_m_r <= 1'b0;
      opt_s_r <= 1'b0;
    end else begin
      sync_m_r <= input_output_a;
      sync_s_r <= sync_m_r;
      opt_m_r <= optical_tx_data;
      opt_s_r <= opt_m_r;
    end
  end

  always_comb begin
    case (state_cnt_r)
      2'h0: states_nxt = STATES_00;
      2'h1: states_nxt = STATES_01;
      2'h2: states_nxt = STATES_10;
      2'h3: states_nxt = STATES_11;
      default: states_nxt = STATES_00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b0;
      input_mux_alternate_select <= ALT_SEL_RESET;
      input_mux_states <= STATES_00;
      input_input_output_a_enable <= SYNC_EN_RESET;
    end else begin
      cpu_clk_en <= cpu_en_int;
      input_mux_alternate_select <= alt_sel_r;
      input_mux_states <= states_nxt;
      input_input_output_a_enable <= sync_en_r;
    end
  end

  // segment seven carries sync when enabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lcd_segment_pin_seven <= SEG_RESET;
    end else if (sync_en_r) begin
      lcd_segment_pin_seven <= {SEG_W{sync_s_r}};
    end else begin
      lcd_segment_pin_seven <= seg_words[SEG_PIN_SYNC];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      optical_transmit_output <= 1'b0;
      optical_transmit_output_oe_n <= 1'b1;
    end else begin
      optical_transmit_output <= opt_s_r;
      optical_transmit_output_oe_n <= opt_dis_r;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (hit(addr, MUX_CTL_ADDR)) begin
      rdata_nxt[STATE_CNT_LSB +: 2] = state_cnt_r;
    end else if (hit(addr, CPU_DIV_ADDR)) begin
      rdata_nxt[DIV_LSB +: DIV_W] = cpu_div_r;
    end else if (hit(addr, MUX_SEL_ADDR)) begin
      rdata_nxt[SYNC_EN_BIT] = sync_en_r;
      rdata_nxt[ALT_SEL_BIT] = alt_sel_r;
    end else if (hit(addr, OPT_CTL_ADDR)) begin
      rdata_nxt[OPT_DIS_BIT] = opt_dis_r;
    end else if (seg_hit(addr)) begin
      rdata_nxt[SEG_W-1:0] = seg_words[seg_idx];
    end
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd_stb) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= '0;
    end
  end
endmodule : mcr_bank
`default_nettype wire

// file: tb/mcr_bank_asserts.sv
// checker: port relations of the misc config bank
`default_nettype none
module mcr_bank_chk
  import mcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic cpu_clk_en,
  input wire logic input_mux_alternate_select,
  input wire logic [2:0] input_mux_states,
  input wire logic [3:0] lcd_segment_pin_seven,
  input wire logic input_input_output_a_enable,
  input wire logic optical_transmit_output_oe_n,
  input wire logic [167:0] lcd_segment_words
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] gap_r;
  logic seen_r;
  logic [2:0] div_q_r;
  logic [8:0] since_r;
  function automatic logic [2:0] states_of(input logic [1:0] c);
    return c == 2'h0 ? 3'h6 : c == 2'h1 ? 3'h4 : c == 2'h2 ? 3'h3 : 3'h2;
  endfunction : states_of
  // spacing of enable pulses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 8'h01;
      seen_r <= 1'b0;
    end else if (cpu_clk_en) begin
      gap_r <= 8'h01;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 8'h01;
    end
  end
  // saturating age so a pending period change has surely landed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q_r <= 3'h0;
      since_r <= 9'h000;
    end else if (wr_stb && addr == CPU_DIV_ADDR) begin
      div_q_r <= wdata[2:0];
      since_r <= 9'h000;
    end else if (since_r != 9'h1FF) begin
      since_r <= since_r + 9'h001;
    end
  end
  opt_dis_a: assert property (
    wr_stb && addr == OPT_CTL_ADDR |-> ##2 optical_transmit_output_oe_n == $past(wdata[5], 2))
    else $error("optical enable wrong");
  alt_sel_a: assert property (
    wr_stb && addr == MUX_SEL_ADDR |-> ##2 input_mux_alternate_select == $past(wdata[2], 2))
    else $error("alternate select wrong");
  sync_en_a: assert property (
    wr_stb && addr == MUX_SEL_ADDR |-> ##2 input_input_output_a_enable == $past(wdata[0], 2))
    else $error("sync enable wrong");
  state_count_a: assert property (
    wr_stb && addr == MUX_CTL_ADDR |-> ##2 input_mux_states == states_of($past(wdata[7:6], 2)))
    else $error("state count wrong");
  seg_read_a: assert property (
    rd_stb && addr == SEG_FIRST_ADDR |=> rdata == {4'h0, lcd_segment_words[3:0]})
    else $error("segment read wrong");
  pin_seven_a: assert property (
    !input_input_output_a_enable [*3] ##0 $stable(lcd_segment_words) |-> lcd_segment_pin_seven == lcd_segment_words[31:28])
    else $error("pin seven wrong");
  clk_glitch_a: assert property (
    cpu_clk_en && seen_r |-> gap_r <= 8'h80 && (gap_r & (gap_r - 8'h01)) == 8'h00)
    else $error("enable gap not a power of two");
  div_period_a: assert property (
    cpu_clk_en && since_r == 9'h1FF |-> gap_r == (8'h01 << div_q_r))
    else $error("enable period wrong");
  cover property (cpu_clk_en && since_r == 9'h1FF && div_q_r == 3'h7);
  cover property (input_input_output_a_enable && lcd_segment_pin_seven == 4'hF);
  cover property (optical_transmit_output_oe_n);
endmodule : mcr_bank_chk
bind mcr_bank mcr_bank_chk mcr_bank_chk_inst (.clock, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
  .cpu_clk_en, .input_mux_alternate_select, .input_mux_states, .lcd_segment_pin_seven,
  .input_input_output_a_enable, .optical_transmit_output_oe_n, .lcd_segment_words);
`default_nettype wire

// file: tb/test_mcr_bank.sv
// testbench: register access and outputs of the misc config bank
`default_nettype none
module test_mcr_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import mcr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic sync_in = 1'b0;
  logic tx_in = 1'b0;
  logic [7:0] rdata;
  logic clk_en, alt, sync_en, tx_out, oe_n;
  logic [2:0] states;
  logic [3:0] pin7;
  logic [167:0] words;
  logic [2:0] exp_st [4] = '{3'h6, 3'h4, 3'h3, 3'h2};
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  mcr_bank mcr_bank_inst (.clock, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .input_output_a(sync_in), .optical_tx_data(tx_in), .cpu_clk_en(clk_en),
    .input_mux_alternate_select(alt), .input_mux_states(states), .lcd_segment_pin_seven(pin7),
    .input_input_output_a_enable(sync_en), .optical_transmit_output(tx_out),
    .optical_transmit_output_oe_n(oe_n), .lcd_segment_words(words));
  always #20 clock = ~clock;
  // hang guard, well above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    chk("rdata", e, rdata);
  endtask : rd
  // covers the two input synchroniser stages as well
  task automatic settle;
    repeat (6) @(negedge clock);
  endtask : settle
  task automatic period(input logic [2:0] v);
    int k;
    wr(CPU_DIV_ADDR, {5'h00, v});
    repeat (560) @(negedge clock);
    k = 0;
    while (clk_en !== 1'b1 && k < 300) begin
      @(negedge clock);
      k++;
    end
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (clk_en !== 1'b1 && k < 300);
    chk("period", 8'h01 << v, 8'(k));
  endtask : period
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(CPU_DIV_ADDR, 8'h00);
    chk("states", 8'h06, states);
    rd(16'h2000, 8'h00);
    repeat (520) @(negedge clock);
    $display("test reset done");
    wr(SEG_FIRST_ADDR, 8'hFA);
    wr(16'h2037, 8'h03);
    wr(SEG_LAST_ADDR, 8'h05);
    settle;
    chk("word0", 8'h0A, words[3:0]);
    chk("word41", 8'h05, words[167:164]);
    chk("pin7", 8'h03, pin7);
    rd(SEG_FIRST_ADDR, 8'h0A);
    rd(SEG_LAST_ADDR, 8'h05);
    $display("test segments done");
    for (int c = 0; c < 4; c++) begin
      wr(MUX_CTL_ADDR, 8'(c << 6));
      settle;
      chk("states", exp_st[c], states);
      rd(MUX_CTL_ADDR, 8'(c << 6));
    end
    $display("test states done");
    @(posedge clock);
    sync_in <= 1'b1;
    wr(MUX_SEL_ADDR, 8'h05);
    settle;
    chk("alt", 8'h01, alt);
    chk("pin7", 8'h0F, pin7);
    chk("sync_en", 8'h01, sync_en);
    rd(MUX_SEL_ADDR, 8'h05);
    @(posedge clock);
    sync_in <= 1'b0;
    settle;
    chk("pin7", 8'h00, pin7);
    wr(MUX_SEL_ADDR, 8'h00);
    settle;
    chk("alt", 8'h00, alt);
    chk("sync_en", 8'h00, sync_en);
    chk("pin7", 8'h03, pin7);
    $display("test mux done");
    @(posedge clock);
    tx_in <= 1'b1;
    wr(OPT_CTL_ADDR, 8'h20);
    settle;
    chk("oe_n", 8'h01, oe_n);
    rd(OPT_CTL_ADDR, 8'h20);
    wr(OPT_CTL_ADDR, 8'h00);
    settle;
    chk("oe_n", 8'h00, oe_n);
    chk("tx", 8'h01, tx_out);
    $display("test optical done");
    for (int v = 7; v >= 0; v--) begin
      period(3'(v));
    end
    $display("test divider done");
    test_done;
  end
endmodule : test_mcr_bank
`default_nettype wire
